// ==== src/asp_ctrl.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "asp_map.svh"
// Summary of operation
// - Select raised edges 2..9 aborts, floats, shuts
// - Select raised before edge 2 keeps normal mode
// - Shutdown powers analog off until select low
// - Select fall in shutdown starts power-up
// - Wake frame aborted before edge 10 reshuts
// - Fully powered after 16 wake cycles
// - Power-on mode set by boot_shut strap; first frame is a dummy
// - 3 zeros, 8 bits MSB first, 5 zeros
// - Drive at select fall, float at 16/rise
// - Rise after edge 10 aborts, stays normal
module asp_ctrl
(
  input  wire logic              clk_sys,
  input  wire logic              rst_n,
  input  wire asp_pkg::asp_pins_t pins,
  input  wire logic [7:0]        sample_in,
  input  wire logic              boot_shut,
  output asp_pkg::asp_sdo_t      sdo,
  output logic                   analog_on,
  output logic                   powered,
  output logic                   sample_take,
  output logic [7:0]             held_sample,
  output logic                   result_valid
);
  logic                sclk_s;
  logic                cs_n_s;
  logic                sclk_prev_q;
  logic                cs_prev_q;
  logic                fall_sclk;
  logic                cs_fall;
  logic                cs_rise;
  logic [4:0]          edges_q;
  logic                frame_q;
  logic [4:0]          wake_q;
  logic                dummy_q;
  logic [15:0]         shift_q;
  asp_pkg::asp_mode_t  mode_q;
  asp_pkg::asp_mode_t  mode_d;

  // Both pins arrive from the host's clock domain
  asp_sync u_sync_sclk
  (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .din     (pins.sclk),
    .init    (1'b1),
    .dout    (sclk_s)
  );
  asp_sync u_sync_cs
  (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .din     (pins.cs_n),
    .init    (1'b1),
    .dout    (cs_n_s)
  );

  // Edge detection on the filtered levels
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      sclk_prev_q <= 1'b1;
      cs_prev_q   <= 1'b1;
    end
    else
    begin
      sclk_prev_q <= sclk_s;
      cs_prev_q   <= cs_n_s;
    end
  end
  assign fall_sclk = sclk_prev_q & ~sclk_s & ~cs_n_s;
  assign cs_fall   = cs_prev_q & ~cs_n_s;
  assign cs_rise   = ~cs_prev_q & cs_n_s;

  // Falling-edge count, saturates at 31, past the frame end
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      edges_q <= 5'd0;
    else if (cs_fall)
      edges_q <= 5'd0;
    else if (fall_sclk && edges_q != 5'd31)
      edges_q <= edges_q + 5'd1;
  end

  // Frame open from select fall to 16th edge or select rise
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      frame_q <= 1'b0;
    else if (cs_fall)
      frame_q <= 1'b1;
    else if (cs_rise || (fall_sclk && edges_q == `ASP_FRAME_EDGES - 5'd1))
      frame_q <= 1'b0;
  end

  // Mode decisions taken on select fall, select rise and the tenth edge in wake; rise checked before the count
  always_comb
  begin
    mode_d = mode_q;
    if (cs_fall && mode_q == asp_pkg::ASP_SHUT)
      mode_d = asp_pkg::ASP_WAKE;
    else if (cs_rise)
    begin
      if (mode_q == asp_pkg::ASP_WAKE && edges_q < `ASP_MODE_EDGE_HI)
        mode_d = asp_pkg::ASP_SHUT;
      else if (edges_q >= `ASP_MODE_EDGE_LO && edges_q < `ASP_MODE_EDGE_HI)
        mode_d = asp_pkg::ASP_SHUT;
      else if (mode_q == asp_pkg::ASP_WAKE)
        mode_d = asp_pkg::ASP_NORM;
      // Fewer than two edges outside wake: mode kept, glitch filter
    end
    else if (mode_q == asp_pkg::ASP_WAKE && fall_sclk &&
             edges_q == `ASP_MODE_EDGE_HI - 5'd1)
      mode_d = asp_pkg::ASP_NORM;
  end

  // Power-on mode is a strap captured on the first cycle after reset
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      mode_q <= asp_pkg::ASP_NORM;
    else if (wake_q == 5'd31)
      mode_q <= boot_shut ? asp_pkg::ASP_SHUT : asp_pkg::ASP_NORM;
    else
      mode_q <= mode_d;
  end

  // Analog powered except in shutdown; strap picks the start
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      analog_on <= 1'b1;
    else if (wake_q == 5'd31)
      analog_on <= ~boot_shut;
    else
      analog_on <= (mode_d != asp_pkg::ASP_SHUT);
  end

  // Wake counter: 16 serial cycles after select fall
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      wake_q <= 5'd31;
    else if (wake_q == 5'd31)
      wake_q <= 5'd0; // either start needs its dummy frame
    else if (mode_d == asp_pkg::ASP_SHUT)
      wake_q <= 5'd0;
    else if (cs_fall && mode_q == asp_pkg::ASP_SHUT)
      wake_q <= 5'd0;
    else if (fall_sclk && wake_q < `ASP_WAKE_CYCLES)
      wake_q <= wake_q + 5'd1;
  end
  assign powered = (wake_q == `ASP_WAKE_CYCLES);

  // First frame after wake is a dummy; its result is flagged invalid
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      dummy_q <= 1'b1;
    else if (cs_fall)
      dummy_q <= (mode_q == asp_pkg::ASP_SHUT) || !powered;
  end

  // Sample and load word at select fall; shift on falling edges
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      shift_q     <= 16'h0000;
      held_sample <= 8'h00;
    end
    else if (cs_fall)
    begin
      held_sample <= sample_in;
      shift_q     <= {3'b000, sample_in, 5'b00000};
    end
    else if (fall_sclk)
      shift_q <= {shift_q[14:0], 1'b0};
  end
  assign sample_take = cs_fall;

  // Valid flag rises when a non-dummy frame finishes all 16 edges
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      result_valid <= 1'b0;
    else if (cs_fall)
      result_valid <= 1'b0;
    else if (fall_sclk && edges_q == `ASP_FRAME_EDGES - 5'd1)
      result_valid <= ~dummy_q;
  end

  // Output driven only inside an open frame
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      sdo <= '0;
    else
    begin
      sdo.oe  <= frame_q & ~cs_rise;
      sdo.out <= shift_q[15];
    end
  end

  msb_first_shift_a:
    assert property (@(posedge clk_sys) disable iff (!rst_n)
      fall_sclk && !cs_fall |=> shift_q == {$past(shift_q[14:0]), 1'b0})
    else $error("serial word not shifted msb first");

  sequence s_cs_high_mid;
    cs_rise && edges_q >= 5'd2 && edges_q < 5'd10 && mode_q == asp_pkg::ASP_NORM;
  endsequence

  abort_enters_shut_a:
    assert property (@(posedge clk_sys) disable iff (!rst_n)
      s_cs_high_mid |=> mode_q == asp_pkg::ASP_SHUT ##1 !sdo.oe)
    else $error("mid-frame abort did not shut down");
  glitch_keeps_mode_a:
    assert property (@(posedge clk_sys) disable iff (!rst_n)
      cs_rise && edges_q < 5'd2 && mode_q != asp_pkg::ASP_WAKE |=> $stable(mode_q))
    else $error("early select rise changed mode");
  shut_analog_off_a:
    assert property (@(posedge clk_sys) disable iff (!rst_n)
      mode_q == asp_pkg::ASP_SHUT && !cs_fall |=> !analog_on)
    else $error("analog powered in shutdown");
  wake_on_fall_a:
    assert property (@(posedge clk_sys) disable iff (!rst_n)
      cs_fall && mode_q == asp_pkg::ASP_SHUT |=> mode_q == asp_pkg::ASP_WAKE && dummy_q)
    else $error("select fall did not start wake");
  wake_abort_shut_a:
    assert property (@(posedge clk_sys) disable iff (!rst_n)
      cs_rise && mode_q == asp_pkg::ASP_WAKE && edges_q < 5'd10 |=>
        mode_q == asp_pkg::ASP_SHUT)
    else $error("aborted wake did not return to shutdown");
  powered_after_16_a:
    assert property (@(posedge clk_sys) disable iff (!rst_n)
      powered |-> wake_q == 5'd16 && mode_q != asp_pkg::ASP_SHUT)
    else $error("powered flag inconsistent");
  float_after_16_a:
    assert property (@(posedge clk_sys) disable iff (!rst_n)
      fall_sclk && edges_q == 5'd15 |-> ##2 !sdo.oe)
    else $error("output still driven after sixteenth edge");
  late_rise_normal_a:
    assert property (@(posedge clk_sys) disable iff (!rst_n)
      cs_rise && edges_q >= 5'd10 && mode_q == asp_pkg::ASP_NORM |=>
        mode_q == asp_pkg::ASP_NORM ##1 !sdo.oe)
    else $error("late select rise left normal mode");
  count_restart_a:
    assert property (@(posedge clk_sys) disable iff (!rst_n)
      cs_fall |=> edges_q == 5'd0)
    else $error("edge count not restarted");
  lead_zero_a:
    assert property (@(posedge clk_sys) disable iff (!rst_n)
      cs_fall |=> shift_q[15:13] == 3'b000 && shift_q[4:0] == 5'b00000)
    else $error("frame word framing wrong");
endmodule
`default_nettype wire

// ==== src/asp_map.svh ====
`ifndef ASP_MAP_SVH
`define ASP_MAP_SVH
// Frame geometry in serial clock falling edges
`define ASP_FRAME_EDGES   5'd16
`define ASP_MODE_EDGE_LO  5'd2
`define ASP_MODE_EDGE_HI  5'd10
`define ASP_LEAD_ZEROS    5'd3
`define ASP_RESULT_BITS   5'd8
// Power-up span in serial clock cycles
`define ASP_WAKE_CYCLES   5'd16
// Throughput limit, serial clocks per conversion
`define ASP_CONV_PERIOD   5'd20
// Host clock limit in kHz and least link half period in system cycles
`define ASP_SCLK_MAX_KHZ  10000
`define ASP_SYS_MHZ       100
`define ASP_HALF_CYC      ((`ASP_SYS_MHZ * 1000) / (2 * `ASP_SCLK_MAX_KHZ))
`endif

// ==== src/asp_pkg.sv ====
package asp_pkg;
  typedef enum logic [1:0] {
    ASP_SHUT = 2'b00,
    ASP_WAKE = 2'b01,
    ASP_NORM = 2'b11
  } asp_mode_t;
  typedef struct packed {
    logic sclk;
    logic cs_n;
  } asp_pins_t;
  typedef struct packed {
    logic out;
    logic oe;
  } asp_sdo_t;
endpackage

// ==== src/asp_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
// Three-stage synchroniser; change accepted when stages two and three agree
module asp_sync
(
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic din,
  input  wire logic init,
  output logic      dout
);
  logic s1_q;
  logic s2_q;
  logic s3_q;

  // First stage is read only by the second
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      s1_q <= init;
      s2_q <= init;
      s3_q <= init;
      dout <= init;
    end
    else
    begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q)
        dout <= s3_q;
    end
  end
endmodule
`default_nettype wire

// ==== verif/asp_host.sv ====
`timescale 1ns/1ps
`default_nettype none
// ****************
// Host serial port
// ****************
module asp_host
(
  input  wire logic              clk_sys,
  input  wire asp_pkg::asp_sdo_t sdo,
  output asp_pkg::asp_pins_t     pins
);
  // Clock idles high and stands still between frames
  initial pins = '{sclk: 1'b1, cs_n: 1'b1};

  // Eight system cycles a half period, 160 ns a link period
  task automatic wt(input int c);
    repeat (c) @(negedge clk_sys);
  endtask

  // Frame of n falls; a bit is taken just before each fall
  task automatic run(input int n, output logic [15:0] w, output logic oe_ok);
    w = 16'h0000;
    oe_ok = 1'b1;
    pins.cs_n = 1'b0;
    wt(8);
    for (int i = 0; i < n; i++)
    begin
      w = {w[14:0], sdo.out};
      if (sdo.oe !== 1'b1) oe_ok = 1'b0;
      pins.sclk = 1'b0;
      wt(8);
      pins.sclk = 1'b1;
      wt(8);
    end
    pins.cs_n = 1'b1;
    wt(64);
  endtask
endmodule
`default_nettype wire

// ==== verif/adc_serial_power_mode_control_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
// *********
// Testbench
// *********
module adc_serial_power_mode_control_tb_top;
  logic               clk_sys = 1'b0;
  logic               rst_n = 1'b0;
  logic [7:0]         sample_in = 8'h00;
  logic               boot_shut = 1'b1;
  asp_pkg::asp_pins_t pins;
  asp_pkg::asp_sdo_t  sdo;
  logic               analog_on;
  logic               powered;
  logic               result_valid;
  logic               sample_take;
  int                 takes = 0;
  logic [7:0]         held_sample;
  logic [15:0]        w;
  logic               oe_ok;
  int                 miscompares = 0;
  int                 comparisons = 0;
  int                 seed = 49;
  int                 shut = 1;
  int                 pw = 0;
  int                 plan[16] = '{16, 16, 16, 1, 5, 0, 12, 9, 3, 10, 16, 16, 2, 16, 15, 16};

  // Clock
  always #5 clk_sys = ~clk_sys;

  asp_ctrl asp_ctrl_inst (
    .clk_sys(clk_sys), .rst_n(rst_n), .pins(pins), .sample_in(sample_in),
    .boot_shut(boot_shut), .sdo(sdo), .analog_on(analog_on), .powered(powered),
    .sample_take(sample_take), .held_sample(held_sample), .result_valid(result_valid));
  asp_host asp_host_inst (.clk_sys(clk_sys), .sdo(sdo), .pins(pins));

  // Select-fall pulses, counted mid-cycle where they are settled
  always @(negedge clk_sys)
    if (sample_take === 1'b1) takes++;

  function automatic int xs(input int v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction

  task automatic chk(input logic ok, input string m);
    comparisons++;
    if (ok !== 1'b1)
    begin
      miscompares++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask

  // One frame against the mode model; unknown power state is skipped
  task automatic frame(input int f);
    int was;
    int p;
    int t;
    was = shut;
    p = pw;
    t = takes;
    seed = xs(seed);
    sample_in = seed[7:0];
    asp_host_inst.run(f, w, oe_ok);
    chk(oe_ok, "output not driven");
    chk(takes == t + 1, "sample pulse count");
    if (f >= 2) chk(held_sample === sample_in, "held sample");
    if (was == 1) shut = (f < 10) ? 1 : 0;
    else if (f >= 2 && f < 10) shut = 1;
    chk(analog_on === (shut == 0), "analog power");
    chk(sdo.oe === 1'b0, "output not floated");
    if (shut == 1) chk(powered === 1'b0, "powered in shutdown");
    if (f < 16) chk(result_valid === 1'b0, "truncated word valid");
    else
    begin
      chk(w === {3'h0, sample_in, 5'h00}, "serial word");
      chk(powered === 1'b1, "not powered");
      if (p != -1) chk(result_valid === (was == 0 && p == 1), "valid flag");
    end
    if (shut == 1) pw = 0;
    else if (f == 16) pw = 1;
    else if (was == 1 || p == 0) pw = -1;
  endtask

  // Power-on with a strap; the model starts in the strapped mode
  task automatic power_on(input logic strap);
    rst_n = 1'b0;
    boot_shut = strap;
    repeat (10) @(negedge clk_sys);
    rst_n = 1'b1;
    repeat (8) @(negedge clk_sys);
    shut = strap ? 1 : 0;
    pw = 0;
    chk(analog_on === ~strap, "start-up mode");
  endtask

  task automatic test_done();
    if (miscompares == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Main sequence: fixed corners, then random frame lengths
  initial
  begin
    power_on(1'b1);
    foreach (plan[i]) frame(plan[i]);
    repeat (30)
    begin
      seed = xs(seed);
      frame(int'(seed[4:0]) % 17);
    end
    // Second start in normal mode; its first frame is a dummy
    power_on(1'b0);
    foreach (plan[i]) frame(plan[i]);
    test_done();
  end

  // Watchdog, well past the expected run length
  initial
  begin
    #400000;
    miscompares++;
    test_done();
  end
endmodule
`default_nettype wire
